/* File: rtl/trsf_pkg.sv */
// constants shared by the torque resonance suppression filter
package trsf_pkg;
  // ------------------------------------------------------------
  // clock and sample timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int SAMPLE_HZ = 40_000;
  localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
  localparam int WINDOW_SAMPLES = SAMPLE_HZ / 2; // half second: crossings equal hertz
  localparam longint STORE_MIN = 30;
  localparam longint STORE_CYCLES = STORE_MIN * 60 * CLK_HZ;
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] LPF_OFS = 8'h04;
  localparam logic [7:0] MON_OFS = 8'h08;
  localparam logic [7:0] NOTCH_OFS = 8'h10; // four words, one per section
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int MODE_LSB = 0;
  localparam int THR_LSB = 4;
  localparam int FREQ_LSB = 0;
  localparam int WID_LSB = 16;
  localparam int DEP_LSB = 24;
  localparam int MONB_LSB = 16;
  // ------------------------------------------------------------
  // reset values and limits
  // ------------------------------------------------------------
  localparam logic [2:0] THR_RST = 3'h4;
  localparam logic [15:0] TC_RST = 16'h0050;   // 0.80 ms in 0.01 ms steps
  localparam logic [15:0] TC_MAX = 16'h09C4;   // 25.00 ms
  localparam logic [12:0] FREQ_RST = 13'h1388; // 5000 Hz, section off
  localparam logic [12:0] FREQ_MIN = 13'h012C; // 300 Hz
  localparam logic [4:0] WID_RST = 5'h02;
  localparam logic [4:0] WID_MAX = 5'h14;
  localparam logic [6:0] DEP_RST = 7'h00;
  localparam logic [6:0] DEP_MAX = 7'h63;
  // ------------------------------------------------------------
  // coefficient scales (q15)
  // ------------------------------------------------------------
  localparam logic [15:0] F_NUM = 16'h1497; // 2*pi/fs*2^25, used >>10
  localparam logic [11:0] Q_STEP = 12'hCCD; // 0.1 per width level
  localparam logic [8:0] G_STEP = 9'h148;   // 0.01 per depth level
  typedef enum logic [2:0] {
    TRSF_MANUAL = 3'h0, TRSF_ONE = 3'h1, TRSF_TWO = 3'h2,
    TRSF_DETECT = 3'h3, TRSF_CLEAR = 3'h4
  } trsf_mode_t;
endpackage : trsf_pkg

/* File: rtl/trsf_top.sv */
// torque resonance suppression filter: apb registers, fifo, lpf, notches
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps

// ------------------------------------------------------------
// sample fifo
// ------------------------------------------------------------
module trsf_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  // honest flags from the occupancy count
  assign in_ready = (cnt_reg != (AW+1)'(DEPTH)); // full only at DEPTH words
  assign out_valid = (cnt_reg != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_reg];

  // storage
  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem[wr_reg] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + AW'(1);
      end
      if (pop)
      begin
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + AW'(1);
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : trsf_fifo

// ------------------------------------------------------------
// one notch section, state-variable form
// ------------------------------------------------------------
module trsf_notch (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic [15:0] x,
  input wire logic [12:0] freq,
  input wire logic [4:0] width,
  input wire logic [6:0] depth,
  output logic [15:0] y_reg,
  output logic vld_reg
);
  logic signed [23:0] low_reg;
  logic signed [23:0] band_reg;
  logic signed [17:0] f_q;
  logic signed [17:0] q_q;
  logic signed [17:0] a_q;
  logic signed [23:0] low_n;
  logic signed [23:0] high;
  logic signed [23:0] band_n;
  logic signed [23:0] bp;
  logic signed [23:0] yw;
  logic [28:0] f_full;

  // coefficients follow the settings seen at this sample only
  always_comb
  begin
    f_full = 29'(freq) * 29'(trsf_pkg::F_NUM);
    f_q = 18'(f_full >> 10);
    q_q = (width == 5'h00) ? 18'sh00001 : 18'(width) * 18'(trsf_pkg::Q_STEP);
    a_q = 18'sh08000 - 18'(depth) * 18'(trsf_pkg::G_STEP);
    if (depth == trsf_pkg::DEP_MAX)
    begin
      a_q = 18'sh00000; // top level passes the center fully
    end
    low_n = low_reg + 24'((42'(f_q) * 42'(band_reg)) >>> 15);
    high = 24'($signed(x)) - low_n - 24'((42'(q_q) * 42'(band_reg)) >>> 15);
    band_n = band_reg + 24'((42'(f_q) * 42'(high)) >>> 15);
    bp = 24'((42'(q_q) * 42'(band_n)) >>> 15);
    yw = 24'($signed(x)) - 24'((42'(a_q) * 42'(bp)) >>> 15);
  end

  // state and saturated output per sample; the top value bypasses
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_reg <= '0;
      band_reg <= '0;
      y_reg <= '0;
      vld_reg <= 1'b0;
    end
    else
    begin
      vld_reg <= en;
      if (en)
      begin
        if (freq >= trsf_pkg::FREQ_RST)
        begin
          y_reg <= x;
          low_reg <= '0;
          band_reg <= '0;
        end
        else
        begin
          low_reg <= low_n;
          band_reg <= band_n;
          if (yw > 24'sh007FFF)
            y_reg <= 16'h7FFF;
          else if (yw < -24'sh008000)
            y_reg <= 16'h8000;
          else
            y_reg <= yw[15:0];
        end
      end
    end
  end
endmodule : trsf_notch

// ------------------------------------------------------------
// resonance detector: zero crossings over half a second
// ------------------------------------------------------------
module trsf_detect (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic signed [16:0] x,
  input wire logic [2:0] thr,
  output logic [15:0] freq_reg,
  output logic done_reg
);
  logic [15:0] win_reg;
  logic [15:0] cross_reg;
  logic sign_reg;
  logic vib_reg;
  logic [16:0] mag;
  logic [16:0] lvl;

  // smaller threshold level means a lower amplitude counts as vibration
  assign mag = x[16] ? 17'(-x) : 17'(x);
  assign lvl = 17'h00040 << thr;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      win_reg <= '0;
      cross_reg <= '0;
      sign_reg <= 1'b0;
      vib_reg <= 1'b0;
      freq_reg <= '0;
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      if (en)
      begin
        sign_reg <= x[16];
        if (mag > lvl)
          vib_reg <= 1'b1;
        if (win_reg == 16'(trsf_pkg::WINDOW_SAMPLES - 1))
        begin
          freq_reg <= vib_reg ? cross_reg : 16'h0000;
          done_reg <= vib_reg;
          win_reg <= '0;
          cross_reg <= '0;
          vib_reg <= 1'b0;
        end
        else
        begin
          win_reg <= win_reg + 16'h0001;
          if (sign_reg != x[16])
            cross_reg <= cross_reg + 16'h0001;
        end
      end
    end
  end
endmodule : trsf_detect

// ------------------------------------------------------------
// top level
// ------------------------------------------------------------
module trsf_top #(
  parameter longint STORE_CYCLES = trsf_pkg::STORE_CYCLES,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [15:0] cmd_data,
  output logic [15:0] out_data,
  output logic out_valid,
  output logic nvm_store
);
  logic [2:0] mode_reg;
  logic [2:0] thr_reg;
  logic [15:0] tc_reg;
  logic [12:0] freq_reg [4];
  logic [4:0] wid_reg [4];
  logic [6:0] dep_reg [4];
  logic [7:0] div_reg;
  logic tick;
  logic fifo_valid;
  logic [15:0] fifo_data;
  logic signed [23:0] lpf_reg;
  logic lpf_vld_reg;
  logic [15:0] sec_y [5];
  logic sec_v [5];
  logic [15:0] mon_a;
  logic [15:0] mon_b;
  logic done_a;
  logic done_b;
  logic [35:0] store_reg;
  logic wr;
  logic [3:0] shift;
  logic [21:0] tau;
  logic signed [23:0] lpf_d;
  logic adaptive;

  // sample rate enable
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      div_reg <= '0;
    else
      div_reg <= (div_reg == 8'(trsf_pkg::SAMPLE_DIV - 1)) ? 8'h00 : div_reg + 8'h01;
  end
  assign tick = (div_reg == 8'h00) & fifo_valid;

  // input samples wait here; one leaves per sample tick
  trsf_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk), .rst_n(rst_n),
    .in_valid(cmd_valid), .in_ready(cmd_ready), .in_data(cmd_data),
    .out_valid(fifo_valid), .out_ready(tick), .out_data(fifo_data)
  );

  // low-pass: 2^shift approximates tau/Ts, zero constant passes directly
  always_comb
  begin
    tau = (22'(tc_reg) * 22'h00001A) >> 6;
    shift = 4'h0;
    for (int i = 0; i < 12; i++)
      if (tau[i])
        shift = 4'(i + 1);
    lpf_d = (24'($signed(fifo_data)) - lpf_reg) >>> shift;
  end
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lpf_reg <= '0;
      lpf_vld_reg <= 1'b0;
    end
    else
    begin
      lpf_vld_reg <= tick;
      if (tick)
        lpf_reg <= (shift == 4'h0) ? 24'($signed(fifo_data)) : lpf_reg + lpf_d;
    end
  end
  assign sec_y[0] = lpf_reg[15:0];
  assign sec_v[0] = lpf_vld_reg;

  // cascade: each section runs once per sample, one cycle after the last
  for (genvar s = 0; s < 4; s++)
  begin : g_sec
    trsf_notch u_notch (
      .mclk(mclk), .rst_n(rst_n), .en(sec_v[s]), .x(sec_y[s]),
      .freq(freq_reg[s]), .width(wid_reg[s]), .depth(dep_reg[s]),
      .y_reg(sec_y[s+1]), .vld_reg(sec_v[s+1])
    );
  end
  assign out_data = sec_y[4];
  assign out_valid = sec_v[4];

  // detectors on the input and on the notch output, each less the low-pass output
  trsf_detect u_det_a (
    .mclk(mclk), .rst_n(rst_n), .en(tick),
    .x(17'($signed(fifo_data)) - 17'($signed(lpf_reg[15:0]))),
    .thr(thr_reg), .freq_reg(mon_a), .done_reg(done_a)
  );
  trsf_detect u_det_b (
    .mclk(mclk), .rst_n(rst_n), .en(sec_v[4]),
    .x(17'($signed(sec_y[4])) - 17'($signed(lpf_reg[15:0]))),
    .thr(thr_reg), .freq_reg(mon_b), .done_reg(done_b)
  );

  // apb: zero wait states, any unmapped access flags an error; out-of-range writes are ignored, but a refused mode code still updates the threshold
  assign pready = 1'b1;
  assign wr = psel & penable & pwrite;
  assign adaptive = (mode_reg == trsf_pkg::TRSF_ONE) | (mode_reg == trsf_pkg::TRSF_TWO);
  always_comb
  begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    if (paddr == trsf_pkg::CTRL_OFS)
      prdata = {25'h0, thr_reg, 1'b0, mode_reg};
    else if (paddr == trsf_pkg::LPF_OFS)
      prdata = {16'h0000, tc_reg};
    else if (paddr == trsf_pkg::MON_OFS)
      prdata = {mon_b, mon_a};
    else if (paddr[7:4] == 4'h1 && paddr[1:0] == 2'b00)
      prdata = {1'b0, dep_reg[paddr[3:2]], 3'h0, wid_reg[paddr[3:2]],
                3'h0, freq_reg[paddr[3:2]]};
    else
      pslverr = psel & penable;
  end

  // control registers
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_reg <= trsf_pkg::TRSF_MANUAL;
      thr_reg <= trsf_pkg::THR_RST;
      tc_reg <= trsf_pkg::TC_RST;
    end
    else if (wr && paddr == trsf_pkg::CTRL_OFS)
    begin
      if (pwdata[trsf_pkg::MODE_LSB +: 3] <= 3'h4)
        mode_reg <= pwdata[trsf_pkg::MODE_LSB +: 3];
      thr_reg <= pwdata[trsf_pkg::THR_LSB +: 3];
    end
    else if (wr && paddr == trsf_pkg::LPF_OFS && pwdata[15:0] <= trsf_pkg::TC_MAX)
      tc_reg <= pwdata[15:0];
  end

  // notch settings: manual writes, adaptive updates, clearing
  for (genvar s = 0; s < 4; s++)
  begin : g_set
    logic lock;
    logic ok;
    assign lock = (s == 2) ? adaptive : ((s == 3) && mode_reg == trsf_pkg::TRSF_TWO);
    assign ok = (pwdata[trsf_pkg::FREQ_LSB +: 13] >= trsf_pkg::FREQ_MIN)
              & (pwdata[trsf_pkg::FREQ_LSB +: 13] <= trsf_pkg::FREQ_RST)
              & (pwdata[trsf_pkg::WID_LSB +: 5] <= trsf_pkg::WID_MAX)
              & (pwdata[trsf_pkg::DEP_LSB +: 7] <= trsf_pkg::DEP_MAX);
    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        freq_reg[s] <= trsf_pkg::FREQ_RST;
        wid_reg[s] <= trsf_pkg::WID_RST;
        dep_reg[s] <= trsf_pkg::DEP_RST;
      end
      else if (s >= 2 && mode_reg == trsf_pkg::TRSF_CLEAR)
      begin
        freq_reg[s] <= trsf_pkg::FREQ_RST;
        wid_reg[s] <= trsf_pkg::WID_RST;
        dep_reg[s] <= trsf_pkg::DEP_RST;
      end
      else if (lock)
      begin
        // manual entry refused while tuning
        if (s == 2 && done_a && mon_a >= 16'(trsf_pkg::FREQ_MIN)
            && mon_a < 16'(trsf_pkg::FREQ_RST))
          freq_reg[s] <= mon_a[12:0];
        if (s == 3 && done_b && mon_b >= 16'(trsf_pkg::FREQ_MIN)
            && mon_b < 16'(trsf_pkg::FREQ_RST))
          freq_reg[s] <= mon_b[12:0];
      end
      else if (wr && ok && paddr == trsf_pkg::NOTCH_OFS + 8'(4 * s))
      begin
        // only software changes these now
        freq_reg[s] <= pwdata[trsf_pkg::FREQ_LSB +: 13];
        wid_reg[s] <= pwdata[trsf_pkg::WID_LSB +: 5];
        dep_reg[s] <= pwdata[trsf_pkg::DEP_LSB +: 7];
      end
    end
  end

  // store request for non-volatile copy while tuning runs
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      store_reg <= '0;
      nvm_store <= 1'b0;
    end
    else
    begin
      nvm_store <= 1'b0;
      if (!adaptive)
        store_reg <= '0;
      else if (store_reg == 36'(STORE_CYCLES - 1))
      begin
        store_reg <= '0;
        nvm_store <= 1'b1;
      end
      else
        store_reg <= store_reg + 36'h1;
    end
  end
endmodule : trsf_top

/* File: sim/trsf_assertions.sv */
// port checker for the torque resonance filter
`timescale 1ns/1ps
module trsf_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] out_data,
  input wire logic out_valid,
  input wire logic nvm_store
);
  // ----------------
  // mode shadow
  // ----------------
  logic [2:0] mode_q;
  logic acc;
  assign acc = psel && penable;
  // refused mode codes leave the shadow alone, as in the block
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      mode_q <= 3'h0;
    else if (acc && pwrite && paddr == trsf_pkg::CTRL_OFS && pwdata[2:0] <= 3'h4)
      mode_q <= pwdata[2:0];
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // ----------------
  // properties
  // ----------------
  chk_ready_always: assert property (pready)
    else $error("pready low");
  chk_out_pulse: assert property (out_valid |=> !out_valid [*8])
    else $error("out_valid not a lone pulse");
  chk_store_pulse: assert property (nvm_store |=> !nvm_store [*8])
    else $error("nvm_store not a lone pulse");
  chk_unmapped_err: assert property (
    acc && (paddr == 8'h0C || paddr > 8'h1C) |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not flagged");
  chk_mapped_ok: assert property (
    acc && paddr inside {8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1C} |-> !pslverr)
    else $error("mapped access flagged");
  chk_reset_out: assert property (
    !$past(rst_n) |-> out_data == 16'h0 && !out_valid && !nvm_store)
    else $error("output not clear after reset");
  chk_clear_dflt: assert property (
    acc && !pwrite && mode_q == 3'h4 && (paddr == 8'h18 || paddr == 8'h1C)
    |-> prdata == 32'h0002_1388)
    else $error("section not at default in clear mode");
  chk_store_idle: assert property (
    !(mode_q inside {3'h1, 3'h2}) && !($past(mode_q, 2) inside {3'h1, 3'h2})
    && !($past(mode_q) inside {3'h1, 3'h2}) |-> !nvm_store)
    else $error("store pulse outside adaptive modes");
endmodule : trsf_checker

bind trsf_top trsf_checker chk_i (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .out_data, .out_valid, .nvm_store);

/* File: sim/trsf_src_model.sv */
// source model standing in for the speed regulator
`timescale 1ns/1ps
module trsf_src_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hold,
  input wire logic [7:0] count,
  input wire logic cmd_ready,
  output logic cmd_valid,
  output logic [15:0] cmd_data
);
  logic [7:0] sent;
  logic [7:0] sent_next;
  logic valid_next;
  // a word in flight is never withdrawn; hold only delays new words
  assign sent_next = sent + ((cmd_valid && cmd_ready) ? 8'h01 : 8'h00);
  assign valid_next = (cmd_valid && !cmd_ready) || (sent_next < count && !hold);
  // idle data toggles so a stale word cannot pass for a fresh one
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sent <= 8'h00;
      cmd_valid <= 1'b0;
      cmd_data <= 16'h0000;
    end
    else
    begin
      sent <= sent_next;
      cmd_valid <= valid_next;
      cmd_data <= valid_next ? 16'h0400 + {8'h00, sent_next} * 16'h0123 : ~cmd_data;
    end
  end
endmodule : trsf_src_model

/* File: sim/trsf_top_tb.sv */
// self-checking bench for the torque resonance filter
`timescale 1ns/1ps
module trsf_top_tb;
  logic mclk, rst_n, psel, penable, pwrite, hold, err, full_seen;
  logic pready, pslverr, cmd_valid, cmd_ready, out_valid, nvm_store;
  logic [7:0] paddr, cnt;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] cmd_data, out_data;
  logic [15:0] outq[$];
  int failures, num_checks, cyc, stores;
  localparam logic [31:0] DFLT = 32'h0002_1388;

  trsf_top #(.STORE_CYCLES(1000), .FIFO_DEPTH(8)) uut (.mclk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cmd_valid, .cmd_ready,
    .cmd_data, .out_data, .out_valid, .nvm_store);
  trsf_src_model src (.mclk, .rst_n, .hold, .count(cnt), .cmd_ready, .cmd_valid, .cmd_data);

  // ----------------
  // clock and monitors
  // ----------------
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // output capture, store count and a hang limit
  always @(posedge mclk)
  begin
    cyc++;
    if (out_valid === 1'b1) outq.push_back(out_data);
    if (nvm_store === 1'b1) stores++;
    if (cmd_ready === 1'b0) full_seen = 1'b1;
    if (cyc == 20000)
    begin
      failures++;
      end_of_test();
    end
  end

  // ----------------
  // shared tasks
  // ----------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; request held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  function automatic logic [31:0] nw(logic [12:0] f, logic [4:0] w, logic [6:0] d);
    return {1'b0, d, 3'h0, w, 3'h0, f};
  endfunction : nw

  // ----------------
  // scenarios
  // ----------------
  task t_regs;
    rdc(8'h00, 32'h0000_0040);
    rdc(8'h04, 32'h0000_0050);
    rdc(8'h08, 32'h0);
    for (int i = 0; i < 4; i++) rdc(8'h10 + 8'(4 * i), DFLT);
    apb(1'b0, 8'h0C, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("regs test done");
  endtask : t_regs
  task t_notch;
    logic [31:0] bad[4];
    logic [31:0] good;
    bad = '{nw(13'h012B, 5'h02, 7'h00), nw(13'h1389, 5'h02, 7'h00),
            nw(13'h03E8, 5'h15, 7'h00), nw(13'h03E8, 5'h02, 7'h64)};
    good = nw(13'h03E8, trsf_pkg::WID_MAX, trsf_pkg::DEP_MAX);
    wr(8'h10, nw(trsf_pkg::FREQ_MIN, 5'h00, 7'h00));
    rdc(8'h10, nw(trsf_pkg::FREQ_MIN, 5'h00, 7'h00));
    wr(8'h10, good);
    rdc(8'h10, good);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h10, bad[i]);
      rdc(8'h10, good);
    end
    wr(8'h10, DFLT);
    $display("notch test done");
  endtask : t_notch
  task t_lpf;
    wr(8'h04, 32'h0000_09C5);
    rdc(8'h04, 32'h0000_0050);
    wr(8'h04, 32'h0000_09C4);
    rdc(8'h04, 32'h0000_09C4);
    wr(8'h04, 32'h0);
    $display("lpf test done");
  endtask : t_lpf
  task t_modes;
    logic [31:0] a3, a4, b;
    a3 = nw(13'h0190, 5'h03, 7'h05);
    a4 = nw(13'h0258, 5'h04, 7'h06);
    b = nw(13'h02BC, 5'h01, 7'h01);
    wr(8'h18, a3);
    wr(8'h1C, a4);
    rdc(8'h18, a3);
    rdc(8'h1C, a4);
    wr(8'h00, 32'h21);
    wr(8'h18, b);
    wr(8'h1C, b);
    rdc(8'h18, a3);
    rdc(8'h1C, b);
    wr(8'h00, 32'h22);
    wr(8'h18, a4);
    wr(8'h1C, a3);
    rdc(8'h18, a3);
    rdc(8'h1C, b);
    wr(8'h00, 32'h33);
    rdc(8'h18, a3);
    wr(8'h00, 32'h35);
    rdc(8'h00, 32'h33);
    wr(8'h00, 32'h04);
    wr(8'h18, b);
    rdc(8'h18, DFLT);
    rdc(8'h1C, DFLT);
    wr(8'h00, 32'h40);
    rdc(8'h18, DFLT);
    $display("mode test done");
  endtask : t_modes
  task t_stream;
    int i;
    full_seen = 1'b0;
    outq.delete();
    cnt <= 8'h0C;
    repeat (600) @(negedge mclk);
    chk(32'(outq.size()), 32'h0);
    hold <= 1'b0;
    i = 0;
    while (outq.size() < 12 && i < 4000)
    begin
      @(negedge mclk);
      i++;
    end
    chk({31'h0, full_seen}, 32'h1);
    chk(32'(outq.size()), 32'h0C);
    for (i = 0; i < outq.size(); i++)
      chk({16'h0, outq[i]}, {16'h0, 16'h0400 + 16'(i) * 16'h0123});
    // a real time constant must land the next step part way between old and new
    wr(8'h04, 32'h0000_0050);
    cnt <= 8'h0E;
    i = 0;
    while (outq.size() < 14 && i < 1000)
    begin
      @(negedge mclk);
      i++;
    end
    chk({31'h0, outq.size() == 14 && outq[12] > 16'h1081 && outq[12] < 16'h11A4}, 32'h1);
    $display("stream test done");
  endtask : t_stream
  task t_store;
    wr(8'h00, 32'h41);
    @(negedge mclk);
    stores = 0;
    repeat (2050) @(negedge mclk);
    chk(32'(stores), 32'h2);
    wr(8'h00, 32'h40);
    @(negedge mclk);
    stores = 0;
    repeat (1500) @(negedge mclk);
    chk(32'(stores), 32'h0);
    $display("store test done");
  endtask : t_store
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test

  // ----------------
  // main sequence
  // ----------------
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hold = 1'b1;
    cnt = 8'h00;
    rst_n = 1'b0;
    failures = 0;
    num_checks = 0;
    cyc = 0;
    stores = 0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_notch();
    t_lpf();
    t_modes();
    t_stream();
    t_store();
    end_of_test();
  end
endmodule : trsf_top_tb
